// ---- include/efe_pkg.sv ----
// Shared constants, types and the CRC step for the Ethernet frame encapsulation block.
// Assumes a byte-wide PHY path and a byte-wide client path, both on the one system clock.
package efe_pkg;

  // Framing bytes and counts
  localparam logic [7:0] EFE_PREAMBLE_BYTE = 8'h55;
  localparam logic [7:0] EFE_SFD_BYTE = 8'hd5;
  localparam logic [15:0] EFE_PREAMBLE_LEN = 16'h0007;
  localparam logic [15:0] EFE_HDR_LEN = 16'h000e;
  localparam logic [15:0] EFE_MIN_BODY = 16'h003c;
  localparam logic [15:0] EFE_MIN_FRAME = 16'h0040;
  localparam logic [15:0] EFE_MIN_DATA = 16'h002e;
  localparam logic [15:0] EFE_HDR_FCS_LEN = 16'h0012;
  localparam logic [15:0] EFE_MAX_FRAME = 16'h05ee;
  localparam logic [15:0] EFE_VLAN_EXTRA = 16'h0004;
  localparam logic [15:0] EFE_FCS_LEN = 16'h0004;
  localparam logic [15:0] EFE_TYPE_MIN = 16'h0600;
  localparam logic [15:0] EFE_TYPE_VLAN = 16'h8100;
  localparam logic [15:0] EFE_TYPE_PAUSE = 16'h8808;

  // Pause frame contents; byte i of a 48-bit address sits at bits [8i+7:8i]
  localparam logic [47:0] EFE_PAUSE_DA = 48'h010000c28001;
  localparam logic [15:0] EFE_PAUSE_OPCODE = 16'h0001;
  localparam logic [15:0] EFE_PAUSE_LAST = 16'h0011;

  // CRC-32, reflected form, shifted LSB first
  localparam logic [31:0] EFE_CRC_INIT = 32'hffffffff;
  localparam logic [31:0] EFE_CRC_POLY = 32'hedb88320;
  localparam logic [31:0] EFE_CRC_RESIDUE = 32'hdebb20e3;

  // Register offsets (byte addresses)
  localparam logic [7:0] EFE_OFS_CTRL = 8'h00;
  localparam logic [7:0] EFE_OFS_MAC_LO = 8'h04;
  localparam logic [7:0] EFE_OFS_MAC_HI = 8'h08;
  localparam logic [7:0] EFE_OFS_PAUSE = 8'h0c;
  localparam logic [7:0] EFE_OFS_RXSTAT = 8'h10;
  localparam logic [7:0] EFE_OFS_RXCNT = 8'h14;

  // Reset values
  localparam logic [4:0] EFE_CTRL_RST = 5'h03;
  localparam logic [47:0] EFE_MAC_RST = 48'h000000000000;
  localparam logic [15:0] EFE_QUANTA_RST = 16'h0000;

  // Control register layout, bit 0 at the bottom
  typedef struct packed {
    logic jumbo;       // Bit 4: no upper frame length limit
    logic len_chk;     // Bit 3: compare length field with data length
    logic rx_fcs_pass; // Bit 2: forward FCS and pad to the client
    logic pad_en;      // Bit 1: pad short transmit frames
    logic fcs_ins;     // Bit 0: append FCS on client frames
  } efe_ctrl_t;

  // Receive frame verdict, bit 0 at the bottom
  typedef struct packed {
    logic is_pause;
    logic is_vlan;
    logic is_bcast;
    logic is_group;
    logic too_long;
    logic runt;
    logic len_err;
    logic bad_fcs;
    logic good;
  } efe_rx_status_t;

  typedef enum logic [4:0] {
    EFE_TX_IDLE = 5'b00001,
    EFE_TX_PRE = 5'b00010,
    EFE_TX_DATA = 5'b00100,
    EFE_TX_PAD = 5'b01000,
    EFE_TX_FCS = 5'b10000
  } efe_tx_state_t;

  typedef enum logic [3:0] {
    EFE_RX_IDLE = 4'b0001,
    EFE_RX_PRE = 4'b0010,
    EFE_RX_DATA = 4'b0100,
    EFE_RX_DROP = 4'b1000
  } efe_rx_state_t;

  // One byte through the CRC, LSB first as it goes on the wire
  function automatic logic [31:0] efe_crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ EFE_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : efe_crc_byte

endpackage : efe_pkg

// ---- src/efe_mac_frame.sv ----
// Ethernet frame encapsulation and decapsulation with an AHB-Lite register slave.
// Assumes byte-wide PHY transmit and receive paths synchronous to clk, and a client
// that keeps tx_valid high from the first byte of a frame to its last.
// Summary of operation
// - Transmit prepends seven 0x55 preamble bytes
// - Receive strips preamble, tolerates its absence
// - Insert 0xD5 delimiter; detect and strip it
// - Classify destination as unicast, group, broadcast
// - Frames start with destination address, unchanged
// - Source address passed unchanged both ways
// - Pause frames carry own unicast source address
// - Length/type 1536 or above means type
// - 0x8100 allows four extra bytes; 0x8808 pause
// - Transmit leaves length/type untouched
// - Receive length strips pad; type passes
// - Optional length check flags mismatch
// - Data 0 to 1500 bytes, jumbo optional
// - Pad frame to 64 bytes including FCS
// - Self-padded frames always get FCS
// - Config bit chooses device or client FCS
// - Pad withheld unless FCS passed to client
// - CRC-32 over header, data and pad
// - FCS sent from x31 down to x0
// - Fields in order, bytes LSB first
// - Every received FCS checked, bad flagged
// - Config bit forwards or strips received FCS
module efe_mac_frame
  import efe_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Client transmit stream
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  output logic tx_ready,
  // PHY transmit
  output logic [7:0] phy_txd,
  output logic phy_tx_en,
  // PHY receive
  input wire logic [7:0] phy_rxd,
  input wire logic phy_rx_dv,
  // Client receive stream
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_done,
  output efe_rx_status_t rx_status
);

  // Register state
  efe_ctrl_t ctrl;            // Steers framing options
  logic [47:0] own_mac;       // Own unicast address
  logic [15:0] pause_quanta;  // Quanta field of the next pause frame
  logic pause_pend;           // Pause frame waiting to go
  logic [15:0] good_cnt;      // Frames received good
  logic [15:0] bad_cnt;       // Frames received bad
  logic wr_pend;              // Write data phase in progress
  logic [7:0] wr_ofs;         // Offset latched in the address phase

  // Bus decode; the upper address bits are not decoded, so the map aliases
  logic ahb_go;
  logic rd_go;
  logic wr_go;
  logic [31:0] rd_word;
  logic wr_ctrl;
  logic wr_mac_lo;
  logic wr_mac_hi;
  logic wr_pause;
  logic wr_rxcnt;
  assign ahb_go = hsel & htrans[1] & hready;
  assign rd_go = ahb_go & ~hwrite;
  assign wr_go = ahb_go & hwrite;
  assign wr_ctrl = wr_pend & (wr_ofs == EFE_OFS_CTRL);
  assign wr_mac_lo = wr_pend & (wr_ofs == EFE_OFS_MAC_LO);
  assign wr_mac_hi = wr_pend & (wr_ofs == EFE_OFS_MAC_HI);
  assign wr_pause = wr_pend & (wr_ofs == EFE_OFS_PAUSE);
  assign wr_rxcnt = wr_pend & (wr_ofs == EFE_OFS_RXCNT);
  // Unmapped offsets read as zero
  assign rd_word = (haddr[7:0] == EFE_OFS_CTRL) ? {27'h0000000, ctrl} :
                   (haddr[7:0] == EFE_OFS_MAC_LO) ? own_mac[31:0] :
                   (haddr[7:0] == EFE_OFS_MAC_HI) ? {16'h0000, own_mac[47:32]} :
                   (haddr[7:0] == EFE_OFS_PAUSE) ? {15'h0000, pause_pend, pause_quanta} :
                   (haddr[7:0] == EFE_OFS_RXSTAT) ? {23'h000000, rx_status} :
                   (haddr[7:0] == EFE_OFS_RXCNT) ? {bad_cnt, good_cnt} : 32'h00000000;

  // Zero-wait slave: read data is loaded at the address-phase edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_pend <= 1'b0;
      wr_ofs <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= wr_go;
      wr_ofs <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (rd_go) begin
        hrdata <= rd_word;
      end
    end
  end

  // Transmit state
  efe_tx_state_t tx_state;
  efe_tx_state_t next_tx_state;
  logic [15:0] tx_cnt;        // Preamble index, then frame byte index
  logic [15:0] next_tx_cnt;
  logic [31:0] tx_crc;
  logic [31:0] next_tx_crc;
  logic tx_is_pause;          // Current frame is generated here
  logic next_tx_is_pause;
  logic tx_add_fcs;           // Current frame gets a device FCS
  logic next_tx_add_fcs;
  logic [7:0] next_phy_txd;
  logic next_phy_tx_en;
  logic tx_start_pause;
  logic tx_take;
  logic [7:0] pause_byte;
  logic [31:0] tx_fcs_word;
  logic tx_short;

  assign tx_take = (tx_state == EFE_TX_DATA) & ~tx_is_pause & tx_valid & tx_ready;
  assign tx_fcs_word = ~tx_crc;
  assign tx_short = (tx_cnt + 16'h0001) < EFE_MIN_BODY;
  assign tx_start_pause = (tx_state == EFE_TX_IDLE) & pause_pend;

  // Pause frame byte by index: group address, own address, type, opcode, quanta
  always_comb begin
    pause_byte = 8'h00;
    if (tx_cnt < 16'h0006) begin
      pause_byte = EFE_PAUSE_DA[8*tx_cnt[2:0] +: 8];
    end else if (tx_cnt < 16'h000c) begin
      pause_byte = own_mac[8*(tx_cnt[3:0] - 4'h6) +: 8];
    end else begin
      case (tx_cnt[4:0])
        5'h0c: pause_byte = EFE_TYPE_PAUSE[15:8];
        5'h0d: pause_byte = EFE_TYPE_PAUSE[7:0];
        5'h0e: pause_byte = EFE_PAUSE_OPCODE[15:8];
        5'h0f: pause_byte = EFE_PAUSE_OPCODE[7:0];
        5'h10: pause_byte = pause_quanta[15:8];
        5'h11: pause_byte = pause_quanta[7:0];
        default: pause_byte = 8'h00;
      endcase
    end
  end

  // Transmit sequencing: preamble, delimiter, body, pad, FCS
  always_comb begin
    next_tx_state = tx_state;
    next_tx_cnt = tx_cnt;
    next_tx_crc = tx_crc;
    next_tx_is_pause = tx_is_pause;
    next_tx_add_fcs = tx_add_fcs;
    next_phy_txd = 8'h00;
    next_phy_tx_en = 1'b0;
    case (tx_state)
      EFE_TX_IDLE: begin
        next_tx_cnt = 16'h0000;
        if (pause_pend || tx_valid) begin
          next_tx_state = EFE_TX_PRE;
          next_tx_is_pause = pause_pend;
          next_tx_add_fcs = pause_pend | ctrl.fcs_ins;
        end
      end
      EFE_TX_PRE: begin
        next_phy_tx_en = 1'b1;
        next_tx_cnt = tx_cnt + 16'h0001;
        if (tx_cnt == EFE_PREAMBLE_LEN) begin
          next_phy_txd = EFE_SFD_BYTE;
          next_tx_state = EFE_TX_DATA;
          next_tx_cnt = 16'h0000;
          next_tx_crc = EFE_CRC_INIT;
        end else begin
          next_phy_txd = EFE_PREAMBLE_BYTE;
        end
      end
      EFE_TX_DATA: begin
        // Client bytes pass untouched, address and length/type included
        if (tx_is_pause || tx_take) begin
          next_phy_tx_en = 1'b1;
          next_phy_txd = tx_is_pause ? pause_byte : tx_data;
          next_tx_crc = efe_crc_byte(tx_crc, next_phy_txd);
          next_tx_cnt = tx_cnt + 16'h0001;
        end
        // A client that drops valid mid-frame ends the frame there
        if ((tx_is_pause && tx_cnt == EFE_PAUSE_LAST) || (!tx_is_pause && (tx_last || !tx_valid))) begin
          if (tx_short && (ctrl.pad_en || tx_is_pause)) begin
            next_tx_state = EFE_TX_PAD;
            next_tx_add_fcs = 1'b1;
          end else if (tx_add_fcs) begin
            next_tx_state = EFE_TX_FCS;
            next_tx_cnt = 16'h0000;
          end else begin
            next_tx_state = EFE_TX_IDLE;
          end
        end
      end
      EFE_TX_PAD: begin
        // Zero pad up to 60 bytes, covered by the CRC
        next_phy_tx_en = 1'b1;
        next_tx_crc = efe_crc_byte(tx_crc, 8'h00);
        next_tx_cnt = tx_cnt + 16'h0001;
        if (!tx_short) begin
          next_tx_state = EFE_TX_FCS;
          next_tx_cnt = 16'h0000;
        end
      end
      EFE_TX_FCS: begin
        // Low byte first, LSB first on the wire, so x31 leads
        next_phy_tx_en = 1'b1;
        next_phy_txd = tx_fcs_word[8*tx_cnt[1:0] +: 8];
        next_tx_cnt = tx_cnt + 16'h0001;
        if (tx_cnt[1:0] == 2'h3) begin
          next_tx_state = EFE_TX_IDLE;
        end
      end
      default: begin
        next_tx_state = EFE_TX_IDLE;
      end
    endcase
  end

  // Transmit registers; ready is a flop so it follows the next state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_state <= EFE_TX_IDLE;
      tx_cnt <= 16'h0000;
      tx_crc <= EFE_CRC_INIT;
      tx_is_pause <= 1'b0;
      tx_add_fcs <= 1'b0;
      tx_ready <= 1'b0;
      phy_txd <= 8'h00;
      phy_tx_en <= 1'b0;
    end else begin
      tx_state <= next_tx_state;
      tx_cnt <= next_tx_cnt;
      tx_crc <= next_tx_crc;
      tx_is_pause <= next_tx_is_pause;
      tx_add_fcs <= next_tx_add_fcs;
      tx_ready <= (next_tx_state == EFE_TX_DATA) & ~next_tx_is_pause;
      phy_txd <= next_phy_txd;
      phy_tx_en <= next_phy_tx_en;
    end
  end

  // Configuration registers; a pause request set by software wins over its clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= efe_ctrl_t'(EFE_CTRL_RST);
      own_mac <= EFE_MAC_RST;
      pause_quanta <= EFE_QUANTA_RST;
      pause_pend <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= efe_ctrl_t'(hwdata[4:0]);
      end
      if (wr_mac_lo) begin
        own_mac[31:0] <= hwdata;
      end
      if (wr_mac_hi) begin
        own_mac[47:32] <= hwdata[15:0];
      end
      if (wr_pause) begin
        pause_quanta <= hwdata[15:0];
        pause_pend <= 1'b1;
      end else if (tx_start_pause) begin
        pause_pend <= 1'b0;
      end
    end
  end

  // Receive state
  efe_rx_state_t rx_state;
  efe_rx_state_t next_rx_state;
  logic [15:0] rx_cnt;       // Bytes after the delimiter, saturating
  logic [31:0] rx_crc;
  logic [3:0][7:0] rx_dly;   // Holds back the last four bytes for FCS stripping
  logic [15:0] rx_lt;        // Length/type field
  logic rx_group;
  logic rx_bcast;
  logic rx_in;               // Frame byte arriving this cycle
  logic rx_end;              // Frame ends this cycle
  logic rx_is_len;
  logic [15:0] rx_idx;       // Index of the byte offered to the client
  logic rx_keep;
  logic [15:0] rx_data_len;
  logic [15:0] rx_max;
  efe_rx_status_t next_rx_status;

  assign rx_in = (rx_state == EFE_RX_DATA) & phy_rx_dv;
  assign rx_end = (rx_state == EFE_RX_DATA) & ~phy_rx_dv;
  assign rx_is_len = rx_lt < EFE_TYPE_MIN;
  assign rx_idx = ctrl.rx_fcs_pass ? rx_cnt : (rx_cnt - EFE_FCS_LEN);
  // Pad is only dropped when the length field says so and FCS is stripped
  assign rx_keep = ctrl.rx_fcs_pass | ((rx_cnt >= EFE_FCS_LEN) &
                   (~rx_is_len | (rx_idx < EFE_HDR_LEN) |
                    (rx_idx < (EFE_HDR_LEN + rx_lt))));
  assign rx_data_len = rx_cnt - EFE_HDR_FCS_LEN;
  // VLAN frames may run four bytes longer; jumbo lifts the limit
  assign rx_max = (rx_lt == EFE_TYPE_VLAN) ? (EFE_MAX_FRAME + EFE_VLAN_EXTRA) : EFE_MAX_FRAME;

  // Frame verdict at the end of reception
  always_comb begin
    next_rx_status = '0;
    next_rx_status.bad_fcs = rx_crc != EFE_CRC_RESIDUE;
    next_rx_status.runt = rx_cnt < EFE_MIN_FRAME;
    next_rx_status.len_err = ctrl.len_chk & rx_is_len & ~next_rx_status.runt &
                             ((rx_lt >= EFE_MIN_DATA) ? (rx_data_len != rx_lt) :
                              (rx_cnt != EFE_MIN_FRAME));
    next_rx_status.too_long = ~ctrl.jumbo & (rx_cnt > rx_max);
    next_rx_status.is_group = rx_group;
    next_rx_status.is_bcast = rx_bcast;
    next_rx_status.is_vlan = rx_lt == EFE_TYPE_VLAN;
    next_rx_status.is_pause = rx_lt == EFE_TYPE_PAUSE;
    next_rx_status.good = ~next_rx_status.bad_fcs & ~next_rx_status.runt &
                          ~next_rx_status.len_err & ~next_rx_status.too_long;
  end

  // Hunt for the delimiter; preamble bytes are skipped, any other byte drops the frame
  always_comb begin
    next_rx_state = rx_state;
    case (rx_state)
      EFE_RX_IDLE, EFE_RX_PRE: begin
        if (!phy_rx_dv) begin
          next_rx_state = EFE_RX_IDLE;
        end else if (phy_rxd == EFE_SFD_BYTE) begin
          next_rx_state = EFE_RX_DATA;
        end else if (phy_rxd == EFE_PREAMBLE_BYTE) begin
          next_rx_state = EFE_RX_PRE;
        end else begin
          next_rx_state = EFE_RX_DROP;
        end
      end
      EFE_RX_DATA: begin
        if (!phy_rx_dv) begin
          next_rx_state = EFE_RX_IDLE;
        end
      end
      EFE_RX_DROP: begin
        if (!phy_rx_dv) begin
          next_rx_state = EFE_RX_IDLE;
        end
      end
      default: begin
        next_rx_state = EFE_RX_IDLE;
      end
    endcase
  end

  // Receive datapath: CRC, field capture, delay line and client output
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_state <= EFE_RX_IDLE;
      rx_cnt <= 16'h0000;
      rx_crc <= EFE_CRC_INIT;
      rx_dly <= '0;
      rx_lt <= 16'h0000;
      rx_group <= 1'b0;
      rx_bcast <= 1'b0;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      rx_state <= next_rx_state;
      rx_valid <= 1'b0;
      if (rx_state != EFE_RX_DATA) begin
        rx_cnt <= 16'h0000;
        rx_crc <= EFE_CRC_INIT;
        rx_bcast <= 1'b1;
      end else if (rx_in) begin
        rx_cnt <= (rx_cnt == 16'hffff) ? rx_cnt : rx_cnt + 16'h0001;
        rx_crc <= efe_crc_byte(rx_crc, phy_rxd);
        rx_dly <= {rx_dly[2:0], phy_rxd};
        if (rx_cnt == 16'h0000) begin
          rx_group <= phy_rxd[0];
        end
        if (rx_cnt < 16'h0006) begin
          rx_bcast <= rx_bcast & (phy_rxd == 8'hff);
        end
        if (rx_cnt == 16'h000c) begin
          rx_lt[15:8] <= phy_rxd;
        end
        if (rx_cnt == 16'h000d) begin
          rx_lt[7:0] <= phy_rxd;
        end
        // Addresses and length/type reach the client unchanged
        rx_valid <= rx_keep;
        rx_data <= ctrl.rx_fcs_pass ? phy_rxd : rx_dly[3];
      end
    end
  end

  // Frame verdict and counters; a frame ending with a clear from software is counted from zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_done <= 1'b0;
      rx_status <= '0;
      good_cnt <= 16'h0000;
      bad_cnt <= 16'h0000;
    end else begin
      rx_done <= rx_end;
      if (rx_end) begin
        rx_status <= next_rx_status;
      end
      good_cnt <= (wr_rxcnt ? 16'h0000 : good_cnt) + {15'h0000, rx_end & next_rx_status.good};
      bad_cnt <= (wr_rxcnt ? 16'h0000 : bad_cnt) + {15'h0000, rx_end & ~next_rx_status.good};
    end
  end

  // Checks on the design's own outputs and internal state
  chk_tx_preamble: assert property (@(posedge clk) disable iff (!rstn)
    $rose(phy_tx_en) |-> (phy_txd == EFE_PREAMBLE_BYTE) [*7])
    else $error("preamble bytes wrong");
  chk_tx_sfd: assert property (@(posedge clk) disable iff (!rstn)
    $rose(phy_tx_en) |-> ##7 (phy_txd == EFE_SFD_BYTE && phy_tx_en))
    else $error("delimiter missing after preamble");
  chk_rx_sfd_entry: assert property (@(posedge clk) disable iff (!rstn)
    ((rx_state == EFE_RX_IDLE || rx_state == EFE_RX_PRE) && phy_rx_dv &&
     phy_rxd == EFE_SFD_BYTE) |=> (rx_state == EFE_RX_DATA))
    else $error("delimiter not accepted");
  chk_rx_no_preamble: assert property (@(posedge clk) disable iff (!rstn)
    rx_valid |-> $past(rx_state) == EFE_RX_DATA)
    else $error("client byte outside frame body");
  chk_tx_passthru: assert property (@(posedge clk) disable iff (!rstn)
    tx_take |=> (phy_tx_en && phy_txd == $past(tx_data)))
    else $error("client byte altered on transmit");
  chk_fcs_first: assert property (@(posedge clk) disable iff (!rstn)
    (tx_state == EFE_TX_FCS && tx_cnt == 16'h0000) |=> (phy_txd == ~$past(tx_crc[7:0])))
    else $error("first FCS byte wrong");
  chk_pad_length: assert property (@(posedge clk) disable iff (!rstn)
    (tx_state == EFE_TX_PAD && next_tx_state == EFE_TX_FCS) |->
    (next_tx_cnt == 16'h0000 && tx_cnt == EFE_MIN_BODY - 16'h0001))
    else $error("pad did not reach minimum length");
  chk_pad_fcs: assert property (@(posedge clk) disable iff (!rstn)
    (tx_state == EFE_TX_PAD) |-> ##[1:60] (tx_state == EFE_TX_FCS))
    else $error("padded frame without FCS");
  chk_pause_src: assert property (@(posedge clk) disable iff (!rstn)
    (tx_is_pause && tx_state == EFE_TX_DATA && tx_cnt == 16'h0006) |=> (phy_txd == own_mac[7:0]))
    else $error("pause source address wrong");
  chk_fcs_strip: assert property (@(posedge clk) disable iff (!rstn)
    (!ctrl.rx_fcs_pass && rx_in && rx_cnt < EFE_FCS_LEN) |=> !rx_valid)
    else $error("held-back bytes leaked");
  chk_bad_fcs_flag: assert property (@(posedge clk) disable iff (!rstn)
    (rx_end && rx_crc != EFE_CRC_RESIDUE) |=> (rx_done && rx_status.bad_fcs && !rx_status.good))
    else $error("bad FCS not reported");
  chk_len_gate: assert property (@(posedge clk) disable iff (!rstn)
    (rx_done && rx_status.len_err) |-> ctrl.len_chk)
    else $error("length error with checking off");

endmodule : efe_mac_frame

// ---- tb/efe_phy_model.sv ----
// Loopback PHY: echoes each transmitted byte on the receive path one cycle later.
// Assumes one clock; an idle receive bus shows the inverse of the idle transmit bus.
module efe_phy_model (
  input wire logic clk,
  input wire logic [7:0] txd,
  input wire logic tx_en,
  output logic [7:0] rxd,
  output logic rx_dv
);
  timeunit 1ns;
  timeprecision 1ns;
  // Echo while enabled, invert the bus when idle
  always @(posedge clk) begin
    rx_dv <= tx_en;
    rxd <= tx_en ? txd : ~txd;
  end
endmodule : efe_phy_model

// ---- tb/tb.sv ----
// Bench for the frame block: AHB control, client transmit, loopback receive.
// Assumes the loopback PHY model; expected bytes come from a queue model.
module tb;
  import efe_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rstn = 0, hsel = 0, hwrite = 0, tx_valid = 0, tx_last = 0;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [7:0] tx_data = 0, phy_txd, phy_rxd, rx_data;
  logic hreadyout, hresp, tx_ready, phy_tx_en, phy_rx_dv, rx_valid, rx_done;
  efe_rx_status_t rx_status;
  int mismatches = 0, checks_done = 0, seed = 32'hbf70, bc, ng = 0, nb = 0;
  int body[100];
  logic [7:0] wq[$], rq[$];
  always #20 clk = ~clk;
  efe_mac_frame efe_mac_frame_inst (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready), .phy_txd(phy_txd),
    .phy_tx_en(phy_tx_en), .phy_rxd(phy_rxd), .phy_rx_dv(phy_rx_dv), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_done(rx_done), .rx_status(rx_status));
  efe_phy_model efe_phy_model_inst (.clk(clk), .txd(phy_txd), .tx_en(phy_tx_en),
    .rxd(phy_rxd), .rx_dv(phy_rx_dv));
  // Record wire bytes and delivered bytes
  always @(posedge clk) begin
    if (phy_tx_en === 1'b1) wq.push_back(phy_txd);
    if (rx_valid === 1'b1) rq.push_back(rx_data);
  end
  task final_report;
    if (mismatches == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One single AHB transfer; zero wait states are not assumed
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk(hresp, 0);
  endtask : ahb
  // Reference CRC step, reflected, LSB first
  function automatic logic [31:0] crc(input logic [31:0] c, input logic [7:0] b);
    c = c ^ {24'h0, b};
    for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ EFE_CRC_POLY : c >> 1;
    return c;
  endfunction : crc
  task fill(input int n, input int lt, input int b);
    for (int i = 0; i < n; i++) body[i] = b && i < 6 ? 255 : $random(seed) & 255;
    body[12] = lt >> 8;
    body[13] = lt & 255;
    bc = b;
  endtask : fill
  // Client stream: hold each byte until taken
  task send(input int n);
    int i;
    i = 0;
    tx_valid <= 1;
    tx_data <= 8'(body[0]);
    tx_last <= n == 1;
    while (i < n) begin
      @(posedge clk);
      if (tx_ready === 1'b1) begin
        i++;
        tx_data <= 8'(body[i % n]);
        tx_last <= i == n - 1;
        tx_valid <= i < n;
      end
    end
  endtask : send
  // A pause run asks the device for its own frame instead of streaming one
  task run(input int n, input logic [4:0] ctl, input bit p);
    logic [31:0] r, c;
    logic [7:0] f[$];
    int m, lt, le, tl, g;
    bit pd;
    f.delete();
    pd = (ctl[1] || p) && n < 60;
    ahb(1, EFE_OFS_CTRL, ctl, r);
    wq.delete();
    rq.delete();
    if (p) ahb(1, EFE_OFS_PAUSE, body[16] * 256 + body[17], r);
    else send(n);
    for (int k = 0; k < 400 && rx_done !== 1'b1; k++) @(negedge clk);
    chk(rx_done, 1);
    c = EFE_CRC_INIT;
    for (int i = 0; i < n; i++) f.push_back(8'(body[i]));
    if (pd) while (f.size() < 60) f.push_back(0);
    foreach (f[i]) c = crc(c, f[i]);
    if (ctl[0] || p || pd) for (int i = 0; i < 4; i++) f.push_back(8'(~c >> (8 * i)));
    chk(wq.size(), f.size() + 8);
    for (int i = 0; i < wq.size() && i < f.size() + 8; i++)
      chk(wq[i], i < 7 ? EFE_PREAMBLE_BYTE : i == 7 ? EFE_SFD_BYTE : f[i - 8]);
    c = EFE_CRC_INIT;
    foreach (f[i]) c = crc(c, f[i]);
    m = ctl[2] ? f.size() : f.size() - 4;
    lt = body[12] * 256 + body[13];
    if (!ctl[2] && lt < 1536 && 14 + lt < m) m = 14 + lt;
    chk(rq.size(), m);
    for (int i = 0; i < rq.size() && i < m; i++) chk(rq[i], f[i]);
    le = ctl[3] && lt < 1536 && f.size() >= 64 && (lt >= 46 ? f.size() - 18 != lt : f.size() != 64);
    tl = !ctl[4] && f.size() > (lt == 16'h8100 ? 1522 : 1518);
    g = c == EFE_CRC_RESIDUE && !le && !tl && f.size() >= 64;
    if (g) ng++;
    else nb++;
    chk(rx_status.good, g);
    chk(rx_status.len_err, le);
    chk(rx_status.runt, f.size() < 64);
    chk(rx_status.too_long, tl);
    chk(rx_status.bad_fcs, c != EFE_CRC_RESIDUE);
    chk(rx_status.is_bcast, bc);
    chk(rx_status.is_group, body[0] & 1);
    chk(rx_status.is_vlan, lt == 16'h8100);
    chk(rx_status.is_pause, lt == 16'h8808);
    @(posedge clk);
  endtask : run
  initial begin
    logic [31:0] r;
    repeat (20) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    ahb(0, EFE_OFS_CTRL, 0, r);
    chk(r, EFE_CTRL_RST);
    ahb(0, 32'h20, 0, r);
    chk(r, 0);
    // Short broadcast with length field, device pads and strips
    fill(20, 6, 1);
    run(20, 5'h03, 0);
    // Typed frame, FCS forwarded to the client
    fill(64, 16'h0800, 0);
    run(64, 5'h07, 0);
    // VLAN frame, client owns the FCS, so it is almost surely bad
    fill(64, 16'h8100, 0);
    run(64, 5'h04, 0);
    // Device pause frame: group address, own address, opcode, random quanta
    fill(18, 16'h8808, 0);
    for (int i = 0; i < 6; i++) body[i] = EFE_PAUSE_DA[8 * i +: 8];
    body[14] = EFE_PAUSE_OPCODE[15:8];
    body[15] = EFE_PAUSE_OPCODE[7:0];
    ahb(1, EFE_OFS_MAC_LO, body[9] << 24 | body[8] << 16 | body[7] << 8 | body[6], r);
    ahb(1, EFE_OFS_MAC_HI, body[11] << 8 | body[10], r);
    run(18, 5'h00, 1);
    ahb(0, EFE_OFS_PAUSE, 0, r);
    chk(r, body[16] * 256 + body[17]);
    // Length checking: padded short frame matches, longer one does not
    fill(20, 6, 0);
    run(20, 5'h0b, 0);
    fill(64, 46, 0);
    run(64, 5'h09, 0);
    // Runt with a type field and no padding, jumbo on
    fill(20, 16'h0800, 0);
    run(20, 5'h11, 0);
    // Frame counters against the model, then a clear
    ahb(0, EFE_OFS_RXCNT, 0, r);
    chk(r, nb << 16 | ng);
    ahb(1, EFE_OFS_RXCNT, 0, r);
    ahb(0, EFE_OFS_RXCNT, 0, r);
    chk(r, 0);
    final_report;
  end
  // Hang guard, far beyond seven frames
  initial begin
    #400000;
    mismatches++;
    final_report;
  end
endmodule : tb
